// ### tsp_pkg.sv
// Shared constants and types of the temperature sensor serial port.
// Assumes a 100 MHz system clock; the alert and port modules import it whole.
package tsp_pkg;

   // System clock rate and the idle timeout of the serial bus
   localparam int unsigned TSP_CLK_HZ = 100_000_000;
   localparam int unsigned TSP_TIMEOUT_MS = 25;
   localparam int unsigned TSP_TIMEOUT_CYC = TSP_TIMEOUT_MS * (TSP_CLK_HZ / 1000);

   // Slave address: fixed upper nibble, then a zero bit, the select input and the option bit
   localparam logic [3:0] TSP_ADDR_PREFIX = 4'h9;

   // Register pointer codes (low three pointer bits)
   localparam logic [2:0] TSP_PTR_TEMP = 3'h0;
   localparam logic [2:0] TSP_PTR_CFG = 3'h1;
   localparam logic [2:0] TSP_PTR_HYST = 3'h2;
   localparam logic [2:0] TSP_PTR_LIMIT = 3'h3;
   localparam logic [2:0] TSP_PTR_ONESHOT = 3'h4;

   // Reset values
   localparam logic [7:0] TSP_PTR_RST = 8'h00;
   localparam logic [7:0] TSP_CFG_RST = 8'h00;
   localparam logic [15:0] TSP_HYST_RST = 16'h4B00;
   localparam logic [15:0] TSP_LIMIT_RST = 16'h5000;

   // Configuration fields; reserved bit 6 always stores zero
   localparam int unsigned TSP_CFG_INT_BIT = 1;
   localparam int unsigned TSP_CFG_POL_BIT = 2;
   localparam logic [7:0] TSP_CFG_WMASK = 8'hBF;

   // Write byte positions after the address byte
   localparam logic [1:0] TSP_IDX_PTR = 2'h0;
   localparam logic [1:0] TSP_IDX_D0 = 2'h1;
   localparam logic [1:0] TSP_IDX_D1 = 2'h2;
   localparam logic [1:0] TSP_IDX_MAX = 2'h3;

   // Bit position of the last bit of a byte
   localparam logic [2:0] TSP_BIT_LAST = 3'h7;

   // Serial engine states
   typedef enum logic [3:0] {
      TSP_ST_IDLE = 4'b0000,
      TSP_ST_ADDR = 4'b0001,
      TSP_ST_ADDR_DONE = 4'b0010,
      TSP_ST_ADDR_ACK = 4'b0011,
      TSP_ST_WR = 4'b0100,
      TSP_ST_WR_DONE = 4'b0101,
      TSP_ST_WR_ACK = 4'b0110,
      TSP_ST_RD = 4'b0111,
      TSP_ST_RD_DONE = 4'b1000,
      TSP_ST_RD_MACK = 4'b1001,
      TSP_ST_RD_NEXT = 4'b1010
   } tsp_state_t;

endpackage

// ### tsp_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level; no bus coherence is given.
`timescale 1ns/10ps
module tsp_sync
#(
   parameter int unsigned WIDTH = 3
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg; // First stage, read only by the second
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg; // Second stage, safe to use
   logic [WIDTH-1:0] sync_next;

   ////////////////////////////////////////////////////////////////
   // Next values: plain shift through two stages
   always_comb
   begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   // Idle bus lines rest high, so reset to ones avoids a false edge
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         meta_reg <= '1;
         sync_reg <= '1;
      end
      else
      begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;

endmodule

// ### tsp_alert.sv
// Over-temperature alert: compares the temperature with the limits.
// Assumes temperature and limits share the system clock domain.
`timescale 1ns/10ps
module tsp_alert
   import tsp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [15:0] temp_value,
   input wire logic [15:0] overtemp_limit,
   input wire logic [15:0] hysteresis_limit,
   input wire logic int_mode,
   input wire logic active_high,
   input wire logic read_clr,
   output logic overtemp_alert_output
);

   logic hot; // Temperature at or above the limit
   logic cool; // Temperature below the hysteresis value
   logic hot_reg; // Previous hot, for the interrupt-mode edge
   logic hot_next;
   logic act_reg; // Alert active, before polarity
   logic act_next;
   logic out_reg; // Pin level after polarity
   logic out_next;

   ////////////////////////////////////////////////////////////////
   // Signed compares; low undefined bits take part as stored
   assign hot = $signed(temp_value) >= $signed(overtemp_limit);
   assign cool = $signed(temp_value) < $signed(hysteresis_limit);

   // Alert state; a new crossing beats a read clear in the same cycle
   always_comb
   begin
      hot_next = hot;
      act_next = act_reg;
      if (int_mode)
      begin
         if (hot && !hot_reg)
            act_next = 1'b1;
         else if (read_clr)
            act_next = 1'b0;
      end
      else if (hot)
         act_next = 1'b1;
      else if (cool)
         act_next = 1'b0;
      out_next = active_high ? act_next : ~act_next;
   end

   // Reset shows the inactive level of the default low-active pin
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         hot_reg <= 1'b0;
         act_reg <= 1'b0;
         out_reg <= 1'b1;
      end
      else
      begin
         hot_reg <= hot_next;
         act_reg <= act_next;
         out_reg <= out_next;
      end
   end

   assign overtemp_alert_output = out_reg;

endmodule

// ### tsp_port.sv
// Two-wire serial slave port of the temperature sensor with its
// pointer, configuration and limit registers.
// Assumes the bus master clocks the link; pins arrive asynchronously.
`timescale 1ns/10ps

// Summary of operation
// - Alert when temperature reaches stored limit
// - Limit is 16-bit two's complement value
// - Limit resets to plus 80 degrees
// - Address is 1001 prefix plus select input
// - First option answers 0x49 or 0x4B
// - Second option answers 0x48 or 0x4A
// - Timeout releases data, waits for start
// - Start, then seven address bits and direction
// - Matching address acknowledged by pulling data low
// - Direction bit zero writes, one reads
// - Eight data bits plus receiver acknowledge
// - Data rising with clock high is stop
// - Direction fixed until a new transfer
// - First written byte loads register pointer
// - Next byte writes configuration register
// - Two data bytes write a limit register
// - Configuration read returns single byte
// - Sixteen-bit read returns high byte first
// - Pointer resets to temperature register
// - Low three pointer bits select register
// - Interrupt-mode read clears active alert
module tsp_port
   import tsp_pkg::*;
#(
   parameter logic OPTION_A = 1'b1,
   parameter int unsigned TIMEOUT_CYCLES = TSP_TIMEOUT_CYC
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic address_select_input,
   input wire logic [15:0] temp_value,
   output logic [7:0] cfg_value,
   output logic overtemp_alert_output
);

   localparam int unsigned TO_W = $clog2(TIMEOUT_CYCLES + 1);

   ////////////////////////////////////////////////////////////////
   // Pin synchronisation and bus events

   logic [2:0] pins_s; // Synchronised scl, sda, select
   logic scl_s; // Clock line, synchronised
   logic sda_s; // Data line, synchronised
   logic sel_s; // Address select, synchronised
   logic scl_p_reg; // Clock one cycle earlier
   logic scl_p_next;
   logic sda_p_reg; // Data one cycle earlier
   logic sda_p_next;
   logic scl_rise; // Clock rising edge seen
   logic scl_fall; // Clock falling edge seen
   logic start_det; // Start condition seen
   logic stop_det; // Stop condition seen
   logic [6:0] dev_addr; // Address this device answers

   tsp_sync #(
      .WIDTH(3)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in({scl_in, sda_in, address_select_input}),
      .sync_out(pins_s)
   );

   assign scl_s = pins_s[2];
   assign sda_s = pins_s[1];
   assign sel_s = pins_s[0];

   assign scl_rise = scl_s && !scl_p_reg;
   assign scl_fall = !scl_s && scl_p_reg;
   // Data may only move while the clock is low, so an edge with it high is framing
   assign start_det = scl_s && scl_p_reg && sda_p_reg && !sda_s;
   assign stop_det = scl_s && scl_p_reg && !sda_p_reg && sda_s;

   // Option picks the lowest address bit; select drives the middle one
   assign dev_addr = {TSP_ADDR_PREFIX, 1'b0, sel_s, OPTION_A};

   ////////////////////////////////////////////////////////////////
   // Serial engine signals

   tsp_state_t state_reg; // Engine state
   tsp_state_t state_next;
   logic [2:0] cnt_reg; // Bit position within a byte
   logic [2:0] cnt_next;
   logic [7:0] shift_reg; // Received byte
   logic [7:0] shift_next;
   logic [7:0] tx_reg; // Byte being sent, MSB out first
   logic [7:0] tx_next;
   logic oe_reg; // Data line pulled low
   logic oe_next;
   logic rw_reg; // Direction latched from the address byte
   logic rw_next;
   logic [1:0] idx_reg; // Byte count in the transfer
   logic [1:0] idx_next;
   logic [15:0] word_reg; // Snapshot of the register being read
   logic [15:0] word_next;
   logic [TO_W-1:0] to_reg; // Cycles without a clock edge
   logic [TO_W-1:0] to_next;
   logic timeout; // Stall limit reached
   logic commit_stb; // A written byte is complete
   logic read_clr; // A read transfer was accepted
   logic [15:0] rd_mux; // Register chosen by the pointer
   logic [7:0] first_byte; // First byte for a read

   ////////////////////////////////////////////////////////////////
   // Register file signals

   logic [7:0] ptr_reg; // Register pointer
   logic [7:0] ptr_next;
   logic [7:0] cfg_reg; // Configuration
   logic [7:0] cfg_next;
   logic [15:0] hyst_reg; // Hysteresis limit
   logic [15:0] hyst_next;
   logic [15:0] limit_reg; // Over-temperature limit
   logic [15:0] limit_next;
   logic [7:0] stage_reg; // High byte waiting for its low byte
   logic [7:0] stage_next;

   ////////////////////////////////////////////////////////////////
   // Read selection; an 8-bit register repeats in both halves so
   // every byte sent is that register
   always_comb
   begin
      case (ptr_reg[2:0])
         TSP_PTR_TEMP: rd_mux = temp_value;
         TSP_PTR_CFG: rd_mux = {cfg_reg, cfg_reg};
         TSP_PTR_HYST: rd_mux = hyst_reg;
         TSP_PTR_LIMIT: rd_mux = limit_reg;
         default: rd_mux = 16'h0000;
      endcase
   end

   assign first_byte = rd_mux[15:8];

   // Timeout only counts while a transfer stands stalled
   assign timeout = (to_reg == TO_W'(TIMEOUT_CYCLES - 1));

   ////////////////////////////////////////////////////////////////
   // Serial engine next state
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      tx_next = tx_reg;
      oe_next = oe_reg;
      rw_next = rw_reg;
      idx_next = idx_reg;
      word_next = word_reg;
      scl_p_next = scl_s;
      sda_p_next = sda_s;
      commit_stb = 1'b0;
      read_clr = 1'b0;
      // Any clock edge proves the master is alive
      if (state_reg == TSP_ST_IDLE || scl_rise || scl_fall)
         to_next = '0;
      else
         to_next = to_reg + 1'b1;
      if (start_det)
      begin
         // Start or repeated start: new transfer, new direction
         state_next = TSP_ST_ADDR;
         cnt_next = 3'h0;
         oe_next = 1'b0;
      end
      else if (stop_det || timeout)
      begin
         // Release the line and wait for the next start
         state_next = TSP_ST_IDLE;
         oe_next = 1'b0;
      end
      else
      begin
         case (state_reg)
            TSP_ST_IDLE:
            begin
               oe_next = 1'b0;
            end
            TSP_ST_ADDR:
            begin
               // Address and direction shift in MSB first
               if (scl_rise)
               begin
                  shift_next = {shift_reg[6:0], sda_s};
                  if (cnt_reg == TSP_BIT_LAST)
                     state_next = TSP_ST_ADDR_DONE;
                  else
                     cnt_next = cnt_reg + 3'h1;
               end
            end
            TSP_ST_ADDR_DONE:
            begin
               // Acknowledge in the low period before the ninth pulse
               if (scl_fall)
               begin
                  if (shift_reg[7:1] == dev_addr)
                  begin
                     state_next = TSP_ST_ADDR_ACK;
                     oe_next = 1'b1;
                     rw_next = shift_reg[0];
                  end
                  else
                     state_next = TSP_ST_IDLE;
               end
            end
            TSP_ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  cnt_next = 3'h0;
                  idx_next = TSP_IDX_PTR;
                  if (rw_reg)
                  begin
                     // Snapshot keeps both halves of one value coherent
                     state_next = TSP_ST_RD;
                     word_next = rd_mux;
                     tx_next = first_byte;
                     oe_next = ~first_byte[7];
                     read_clr = 1'b1;
                  end
                  else
                  begin
                     state_next = TSP_ST_WR;
                     oe_next = 1'b0;
                  end
               end
            end
            TSP_ST_WR:
            begin
               if (scl_rise)
               begin
                  shift_next = {shift_reg[6:0], sda_s};
                  if (cnt_reg == TSP_BIT_LAST)
                     state_next = TSP_ST_WR_DONE;
                  else
                     cnt_next = cnt_reg + 3'h1;
               end
            end
            TSP_ST_WR_DONE:
            begin
               // Device is the receiver, so it acknowledges each byte
               if (scl_fall)
               begin
                  state_next = TSP_ST_WR_ACK;
                  oe_next = 1'b1;
                  commit_stb = 1'b1;
               end
            end
            TSP_ST_WR_ACK:
            begin
               // Any number of bytes may follow; extras are acknowledged
               if (scl_fall)
               begin
                  state_next = TSP_ST_WR;
                  oe_next = 1'b0;
                  cnt_next = 3'h0;
                  if (idx_reg != TSP_IDX_MAX)
                     idx_next = idx_reg + 2'h1;
               end
            end
            TSP_ST_RD:
            begin
               // Data changes only while the clock is low
               if (scl_rise)
               begin
                  if (cnt_reg == TSP_BIT_LAST)
                     state_next = TSP_ST_RD_DONE;
                  else
                     cnt_next = cnt_reg + 3'h1;
               end
               else if (scl_fall)
               begin
                  tx_next = {tx_reg[6:0], 1'b0};
                  oe_next = ~tx_reg[6];
               end
            end
            TSP_ST_RD_DONE:
            begin
               // Free the line for the master's acknowledge
               if (scl_fall)
               begin
                  state_next = TSP_ST_RD_MACK;
                  oe_next = 1'b0;
               end
            end
            TSP_ST_RD_MACK:
            begin
               // No acknowledge ends the read; the stop follows
               if (scl_rise)
               begin
                  if (!sda_s)
                     state_next = TSP_ST_RD_NEXT;
                  else
                     state_next = TSP_ST_IDLE;
               end
            end
            TSP_ST_RD_NEXT:
            begin
               // Alternate high and low halves of the snapshot
               if (scl_fall)
               begin
                  state_next = TSP_ST_RD;
                  cnt_next = 3'h0;
                  idx_next = {1'b0, ~idx_reg[0]};
                  if (idx_reg[0])
                  begin
                     tx_next = word_reg[15:8];
                     oe_next = ~word_reg[15];
                  end
                  else
                  begin
                     tx_next = word_reg[7:0];
                     oe_next = ~word_reg[7];
                  end
               end
            end
            default:
            begin
               state_next = TSP_ST_IDLE;
               oe_next = 1'b0;
            end
         endcase
      end
   end

   // Serial engine registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_reg <= TSP_ST_IDLE;
         cnt_reg <= 3'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         oe_reg <= 1'b0;
         rw_reg <= 1'b0;
         idx_reg <= 2'h0;
         word_reg <= 16'h0000;
         to_reg <= '0;
         scl_p_reg <= 1'b1;
         sda_p_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         tx_reg <= tx_next;
         oe_reg <= oe_next;
         rw_reg <= rw_next;
         idx_reg <= idx_next;
         word_reg <= word_next;
         to_reg <= to_next;
         scl_p_reg <= scl_p_next;
         sda_p_reg <= sda_p_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Register file next values on each written byte
   always_comb
   begin
      ptr_next = ptr_reg;
      cfg_next = cfg_reg;
      hyst_next = hyst_reg;
      limit_next = limit_reg;
      stage_next = stage_reg;
      if (commit_stb)
      begin
         case (idx_reg)
            TSP_IDX_PTR: ptr_next = shift_reg;
            TSP_IDX_D0:
            begin
               stage_next = shift_reg;
               // One-shot and read-only targets store nothing
               if (ptr_reg[2:0] == TSP_PTR_CFG)
                  cfg_next = shift_reg & TSP_CFG_WMASK;
            end
            TSP_IDX_D1:
            begin
               if (ptr_reg[2:0] == TSP_PTR_HYST)
                  hyst_next = {stage_reg, shift_reg};
               else if (ptr_reg[2:0] == TSP_PTR_LIMIT)
                  limit_next = {stage_reg, shift_reg};
            end
            default:
            begin
               stage_next = stage_reg;
            end
         endcase
      end
   end

   // Register file registers with power-on values
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ptr_reg <= TSP_PTR_RST;
         cfg_reg <= TSP_CFG_RST;
         hyst_reg <= TSP_HYST_RST;
         limit_reg <= TSP_LIMIT_RST;
         stage_reg <= 8'h00;
      end
      else
      begin
         ptr_reg <= ptr_next;
         cfg_reg <= cfg_next;
         hyst_reg <= hyst_next;
         limit_reg <= limit_next;
         stage_reg <= stage_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Alert output and pins

   tsp_alert u_alert (
      .clk_sys(clk_sys),
      .rst(rst),
      .temp_value(temp_value),
      .overtemp_limit(limit_reg),
      .hysteresis_limit(hyst_reg),
      .int_mode(cfg_reg[TSP_CFG_INT_BIT]),
      .active_high(cfg_reg[TSP_CFG_POL_BIT]),
      .read_clr(read_clr),
      .overtemp_alert_output(overtemp_alert_output)
   );

   // Open drain: the line is only ever pulled low
   assign sda_out = 1'b0;
   assign sda_oe = oe_reg;
   assign cfg_value = cfg_reg;

endmodule

// ### tsp_port_sva.sv
// Checker for the serial port pins and configuration output.
// Assumes binding onto the port with the same timeout parameter.
`timescale 1ns/10ps
module tsp_port_sva
#(
   parameter int unsigned TIMEOUT_CYCLES = 2000
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [7:0] cfg_value,
   input wire logic overtemp_alert_output
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////
   // Cycles the data line has been held low without a break
   logic [31:0] oe_cnt_reg;
   logic [31:0] oe_cnt_next;
   always_comb
   begin
      oe_cnt_next = sda_oe ? oe_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
   end
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         oe_cnt_reg <= 32'h0000_0000;
      else
         oe_cnt_reg <= oe_cnt_next;
   end
   ////////////////////////////////////////////////////////////////
   a_oe_rst_idle: assert property ($fell(rst) |-> !sda_oe)
      else $error("data pulled low after reset");
   a_drive_zero: assert property (sda_out == 1'b0)
      else $error("data driven high");
   a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("data changed with clock high");
   a_oe_hold_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("data moved during clock high");
   a_cfg_rst_val: assert property ($fell(rst) |-> cfg_value == 8'h00)
      else $error("configuration reset value");
   a_alert_rst: assert property ($fell(rst) |-> overtemp_alert_output)
      else $error("alert active after reset");
   a_cfg_reserved: assert property (cfg_value[6] == 1'b0)
      else $error("reserved bit stored");
   a_cfg_on_ack: assert property ($changed(cfg_value) |-> sda_oe || $past(sda_oe))
      else $error("configuration changed outside ack");
   a_oe_timeout: assert property (oe_cnt_reg <= TIMEOUT_CYCLES + 16)
      else $error("data held past timeout");
   c_ack: cover property ($rose(sda_oe));
   c_cfg: cover property ($changed(cfg_value));
   c_alert: cover property ($fell(overtemp_alert_output));
   c_alert_clr: cover property ($rose(overtemp_alert_output));
endmodule

// ### tsp_mst.sv
// Behavioural two-wire bus master for the port's far side.
// Assumes a pull-up on the data wire; drives it only low.
`timescale 1ns/10ps
module tsp_mst
(
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   localparam realtime Q = 31.25;
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Data set in the low phase, sampled mid high phase
   task automatic bit_x(input logic b, output logic r);
   begin
      sda_low = !b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q scl = 1'b0;
      #Q;
   end
   endtask
   // Start: data falls while clock high
   task automatic start();
   begin
      sda_low = 1'b0;
      #Q scl = 1'b1;
      #Q sda_low = 1'b1;
      #Q scl = 1'b0;
      #Q;
   end
   endtask
   // Stop: data rises while clock high
   task automatic stop();
   begin
      sda_low = 1'b1;
      #Q scl = 1'b1;
      #Q sda_low = 1'b0;
      #(2 * Q);
   end
   endtask
   // MSB first, then the receiver's acknowledge
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
   begin
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = !r;
   end
   endtask
   // Last byte left unacknowledged by the caller
   task automatic recv(input logic ack, output logic [7:0] d);
      logic r;
   begin
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(!ack, r);
   end
   endtask
endmodule

// ### test_tsp_port.sv
// Top bench: master model on the wire, register traffic checks.
// Assumes the port with option A and a short timeout.
`timescale 1ns/10ps
module test_tsp_port;
   localparam int unsigned TO = 2000;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic sel = 1'b0;
   logic [15:0] temp = 16'h0A2B;
   logic [6:0] dev = 7'h49;
   logic scl, m_low, sda_out, sda_oe, alert, a;
   logic [7:0] cfg;
   wire sda_w;
   int err_count = 0;
   int comparisons = 0;
   int cyc = 0;
   // Open-drain wire with pull-up
   assign sda_w = !(m_low || (sda_oe && !sda_out));
   always #5 clk_sys = !clk_sys;
   tsp_port #(.OPTION_A(1'b1), .TIMEOUT_CYCLES(TO)) u_dut (.clk_sys(clk_sys), .rst(rst), .scl_in(scl),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .address_select_input(sel),
      .temp_value(temp), .cfg_value(cfg), .overtemp_alert_output(alert));
   tsp_mst u_mst (.sda(sda_w), .scl(scl), .sda_low(m_low));
   ////////////////////////////////////////////////////////////////
   task automatic complete_run();
   begin
      $display("comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
   begin
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   // Pointer byte then n data bytes, every byte acknowledged
   task automatic wr_reg(input logic [7:0] p, input int n, input logic [15:0] d);
      logic [7:0] b [4];
      logic ok;
   begin
      b = '{{dev, 1'b0}, p, d[15:8], d[7:0]};
      ok = 1'b1;
      u_mst.start();
      for (int i = 0; i < n + 2; i++)
      begin
         u_mst.send(b[i], a);
         ok = ok & a;
      end
      u_mst.stop();
      chk({ok, 16'h0000}, 17'h1_0000);
   end
   endtask
   // Read of n bytes, high byte first
   task automatic rd_reg(input int n, input logic [15:0] e);
      logic [15:0] v;
      logic [7:0] d;
   begin
      v = 16'h0000;
      u_mst.start();
      u_mst.send({dev, 1'b1}, a);
      for (int i = 0; i < n; i++)
      begin
         u_mst.recv(i < n - 1, d);
         v = {v[7:0], d};
      end
      u_mst.stop();
      chk({a, v}, {1'b1, e});
   end
   endtask
   task automatic probe(input logic [6:0] ad, input logic e);
   begin
      u_mst.start();
      u_mst.send({ad, 1'b0}, a);
      u_mst.stop();
      chk({a, 16'h0000}, {e, 16'h0000});
   end
   endtask
   ////////////////////////////////////////////////////////////////
   // Hang guard
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         err_count++;
         complete_run();
      end
   end
   initial
   begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({sda_oe, alert, 7'h00, cfg}, 17'h0_8000);
      rd_reg(2, 16'h0A2B);
      wr_reg(8'h03, 0, 16'h0000);
      rd_reg(2, 16'h5000);
      wr_reg(8'h03, 2, 16'h1234);
      rd_reg(2, 16'h1234);
      chk({16'h0000, alert}, 17'h0_0001);
      @(posedge clk_sys);
      temp <= 16'h1234;
      repeat (4) @(posedge clk_sys);
      chk({16'h0000, alert}, 17'h0_0000);
      wr_reg(8'h01, 1, 16'hC100);
      chk({9'h000, cfg}, 17'h0_0081);
      rd_reg(1, 16'h0081);
      // Interrupt mode keeps the active alert until a read is accepted
      wr_reg(8'h01, 1, 16'h0200);
      chk({16'h0000, alert}, 17'h0_0000);
      rd_reg(1, 16'h0002);
      chk({16'h0000, alert}, 17'h0_0001);
      probe(7'h48, 1'b0);
      probe(7'h4B, 1'b0);
      @(posedge clk_sys);
      sel <= 1'b1;
      repeat (4) @(posedge clk_sys);
      probe(7'h4B, 1'b1);
      probe(7'h49, 1'b0);
      dev = 7'h4B;
      // Temperature high byte has a zero MSB, so the device holds the line low
      wr_reg(8'h00, 0, 16'h0000);
      u_mst.start();
      u_mst.send({dev, 1'b1}, a);
      repeat (4) @(posedge clk_sys);
      chk({a, 15'h0000, sda_oe}, 17'h1_0001);
      repeat (TO + 8) @(posedge clk_sys);
      chk({16'h0000, sda_oe}, 17'h0_0000);
      u_mst.stop();
      probe(7'h4B, 1'b1);
      complete_run();
   end
endmodule
bind tsp_port tsp_port_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sva (.clk_sys(clk_sys), .rst(rst),
   .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .cfg_value(cfg_value),
   .overtemp_alert_output(overtemp_alert_output));
